// >>> src/apll_ctrl.sv
/*
  Control and status logic of the audio clock generator, an APB slave.
  Assumes the analog loop, clock mux, squarer, bias and reference
  oscillator sit outside and take the registered controls driven here.
*/
//
// Contract
// - Bypass code disables loop, clock from master.
// - Normal code enables loop, fixed master multiple.
// - Tracking code follows word clock; code three reserved.
// - Mode field bits seven to six, resets bypass.
// - Bit four enables master clock squarer.
// - Five-bit upper fraction field, resets zero.
// - Eight-bit lower fraction field, resets zero.
// - Integer write commits integer and fraction together.
// - Status bits zero, three, four, seven.
// - Status bit four means active; resets zero.
// - Bit seven enables the trimming engine.
// - Oscillator runs without master clock, out of standby.
// - Writing one to start bit together with bit seven runs trimming.
// - Trim result read-only five bits, resets zero.
// - Bit three enables master bias, resets enabled.
`timescale 1ns/100ps
`default_nettype none
module apll_ctrl
  import apll_pkg::*;
#(
  parameter int ACT_CYC  = ACT_WINDOW_CYC,
  parameter int STEP_CYC = TRIM_STEP_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  input  wire logic        ce_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [9:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        mclk_i,
  input  wire logic        wclk_i,
  input  wire logic        loop_lock_i,
  input  wire logic        track_lock_i,
  input  wire logic        osc_fast_i,
  input  wire logic        standby_i,
  output logic             loop_en_o,
  output logic [1:0]       clk_src_o,
  output logic             sqr_en_o,
  output logic [2:0]       ref_band_o,
  output logic [6:0]       fb_int_o,
  output logic [12:0]      fb_frac_o,
  output logic             osc_run_o,
  output logic [4:0]       osc_trim_o,
  output logic             trim_busy_o,
  output logic             bias_en_o,
  output logic             irq_o
);

  logic [1:0]        mode_reg;
  logic              sqr_reg;
  logic [2:0]        band_reg;
  logic [4:0]        frac_hi_reg;
  logic [7:0]        frac_lo_reg;
  logic [6:0]        int_reg;
  logic [7:0]        status_reg;
  logic              cal_en_reg;
  logic [4:0]        trim_reg;
  logic              bias_reg;
  logic [NUM_EV-1:0] irq_stat_reg;
  logic [NUM_EV-1:0] irq_mask_reg;
  logic [NUM_EV-1:0] ev_next;
  logic [4:0]        s1_reg;
  logic [4:0]        s2_reg;
  logic [4:0]        s3_reg;
  logic [4:0]        filt_reg;
  logic [1:0]        edge_prev_reg;
  logic [15:0]       act_cnt_reg [2];
  logic [1:0]        act_reg;
  logic [2:0]        bit_reg;
  logic [15:0]       step_cnt_reg;
  logic [7:0]        status_next;
  logic [7:0]        rd_next;
  logic [7:0]        idx;
  logic              access;
  logic              wr_en;
  logic              mapped;
  logic              loop_on;
  logic              start_trim;

  typedef enum logic {TRIM_IDLE, TRIM_RUN} apll_trim_t;
  apll_trim_t trim_state_reg;

  assign idx     = paddr_i[9:2];
  assign access  = psel_i && penable_i;
  assign wr_en   = access && pready_o && pwrite_i && mapped;
  assign loop_on = (mode_reg == MODE_NORMAL) || (mode_reg == MODE_TRACK);
  assign start_trim = wr_en && (idx == IDX_OSC_TRIM) && pwdata_i[CAL_START_BIT]
                      && pwdata_i[CAL_EN_BIT] && (trim_state_reg == TRIM_IDLE);

  always_comb begin
    mapped = (paddr_i[1:0] == 2'h0);
    unique case (idx)
      IDX_LOOP_CTRL, IDX_FRAC_HIGH, IDX_FRAC_LOW, IDX_INTEGER, IDX_STATUS,
      IDX_OSC_TRIM, IDX_REF_EN, IDX_IRQ_STAT, IDX_IRQ_MASK: begin
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  always_comb begin
    rd_next = 8'h00;
    unique case (idx)
      IDX_LOOP_CTRL: rd_next = {mode_reg, 1'b0, sqr_reg, 1'b0, band_reg};
      IDX_FRAC_HIGH: rd_next = {3'h0, frac_hi_reg};
      IDX_FRAC_LOW:  rd_next = frac_lo_reg;
      IDX_INTEGER:   rd_next = {1'b0, int_reg};
      IDX_STATUS:    rd_next = status_reg;
      IDX_OSC_TRIM:  rd_next = {cal_en_reg, trim_busy_o, 1'b0, trim_reg};
      IDX_REF_EN:    rd_next = {4'h0, bias_reg, 3'h0};
      IDX_IRQ_STAT:  rd_next = {4'h0, irq_stat_reg};
      IDX_IRQ_MASK:  rd_next = {4'h0, irq_mask_reg};
      default:       rd_next = 8'h00;
    endcase
  end

  // Bus answer one cycle into the access phase.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end else if (ce_i) begin
      pready_o  <= access && !pready_o;
      pslverr_o <= access && !pready_o && !mapped;
      if (access && !pready_o) begin
        prdata_o <= (mapped && !pwrite_i) ? {24'h00_0000, rd_next} : 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      mode_reg    <= MODE_BYPASS;
      sqr_reg     <= 1'b0;
      band_reg    <= RST_INDIV;
      frac_hi_reg <= 5'h00;
      frac_lo_reg <= 8'h00;
      int_reg     <= RST_INTEGER;
      cal_en_reg  <= 1'b0;
      bias_reg    <= RST_BIAS;
      irq_mask_reg <= '0;
    end else if (ce_i && wr_en) begin
      unique case (idx)
        IDX_LOOP_CTRL: begin
          mode_reg <= pwdata_i[MODE_LSB +: 2];
          sqr_reg  <= pwdata_i[SQR_BIT];
          band_reg <= pwdata_i[2:0];
        end
        IDX_FRAC_HIGH: frac_hi_reg <= pwdata_i[4:0];
        IDX_FRAC_LOW:  frac_lo_reg <= pwdata_i[7:0];
        IDX_INTEGER:   int_reg <= pwdata_i[6:0];
        IDX_OSC_TRIM:  cal_en_reg <= pwdata_i[CAL_EN_BIT];
        IDX_REF_EN:    bias_reg <= pwdata_i[BIAS_BIT];
        IDX_IRQ_MASK:  irq_mask_reg <= pwdata_i[NUM_EV-1:0];
        default: begin
        end
      endcase
    end
  end

  // The loop sees the feedback divider only when the integer is written.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      fb_int_o  <= RST_INTEGER;
      fb_frac_o <= 13'h0000;
    end else if (ce_i && wr_en && idx == IDX_INTEGER) begin
      fb_int_o  <= pwdata_i[6:0];
      fb_frac_o <= {frac_hi_reg, frac_lo_reg};
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      loop_en_o  <= 1'b0;
      clk_src_o  <= SRC_MCLK;
      sqr_en_o   <= 1'b0;
      ref_band_o <= RST_INDIV;
      bias_en_o  <= RST_BIAS;
      osc_run_o  <= 1'b0;
    end else if (ce_i) begin
      loop_en_o  <= loop_on;
      unique case (mode_reg)
        MODE_NORMAL: clk_src_o <= SRC_LOOP_MCLK;
        MODE_TRACK:  clk_src_o <= SRC_LOOP_WCLK;
        default:     clk_src_o <= SRC_MCLK;
      endcase
      sqr_en_o   <= sqr_reg;
      ref_band_o <= band_reg;
      bias_en_o  <= bias_reg;
      osc_run_o  <= !status_reg[ST_MCLK_BIT] && !standby_i;
    end
  end

  // Pin inputs: three flops, a change counts when the last two agree.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s1_reg   <= '0;
      s2_reg   <= '0;
      s3_reg   <= '0;
      filt_reg <= '0;
    end else if (ce_i) begin
      s1_reg   <= {osc_fast_i, track_lock_i, loop_lock_i, wclk_i, mclk_i};
      s2_reg   <= s1_reg;
      s3_reg   <= s2_reg;
      filt_reg <= (s2_reg & s3_reg) | (filt_reg & (s2_reg | s3_reg));
    end
  end

  // A clock counts as present while edges keep arriving in the window.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      edge_prev_reg <= '0;
      act_reg       <= '0;
      for (int i = 0; i < 2; i++) begin
        act_cnt_reg[i] <= 16'h0000;
      end
    end else if (ce_i) begin
      edge_prev_reg <= filt_reg[1:0];
      for (int i = 0; i < 2; i++) begin
        if (filt_reg[i] != edge_prev_reg[i]) begin
          act_cnt_reg[i] <= 16'(ACT_CYC);
          act_reg[i]     <= 1'b1;
        end else if (act_cnt_reg[i] != 16'h0000) begin
          act_cnt_reg[i] <= act_cnt_reg[i] - 16'h0001;
        end else begin
          act_reg[i] <= 1'b0;
        end
      end
    end
  end

  always_comb begin
    status_next = 8'h00;
    status_next[ST_MCLK_BIT] = act_reg[0];
    status_next[ST_LOCK_BIT] = loop_on && filt_reg[2];
    status_next[ST_ACT_BIT]  = loop_on && ((mode_reg == MODE_TRACK) ? act_reg[1] : act_reg[0]);
    status_next[ST_SRM_BIT]  = (mode_reg == MODE_TRACK) && filt_reg[3];
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      status_reg <= 8'h00;
    end else if (ce_i) begin
      status_reg <= status_next;
    end
  end

  // Successive approximation of the trim code, one bit per step.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      trim_state_reg <= TRIM_IDLE;
      bit_reg        <= 3'h0;
      step_cnt_reg   <= 16'h0000;
      osc_trim_o     <= 5'h00;
      trim_reg       <= 5'h00;
      trim_busy_o    <= 1'b0;
    end else if (ce_i) begin
      unique case (trim_state_reg)
        TRIM_IDLE: begin
          if (start_trim) begin
            trim_state_reg <= TRIM_RUN;
            trim_busy_o    <= 1'b1;
            bit_reg        <= 3'h4;
            step_cnt_reg   <= 16'(STEP_CYC);
            osc_trim_o     <= 5'h10;
          end
        end
        TRIM_RUN: begin
          if (!cal_en_reg) begin
            trim_state_reg <= TRIM_IDLE;
            trim_busy_o    <= 1'b0;
            osc_trim_o     <= trim_reg;
          end else if (step_cnt_reg != 16'h0001) begin
            step_cnt_reg <= step_cnt_reg - 16'h0001;
          end else begin
            step_cnt_reg <= 16'(STEP_CYC);
            if (bit_reg == 3'h0) begin
              trim_state_reg <= TRIM_IDLE;
              trim_busy_o    <= 1'b0;
              osc_trim_o[0]  <= !filt_reg[4];
              trim_reg       <= {osc_trim_o[4:1], !filt_reg[4]};
            end else begin
              osc_trim_o[bit_reg]         <= !filt_reg[4];
              osc_trim_o[bit_reg - 3'h1] <= 1'b1;
              bit_reg                     <= bit_reg - 3'h1;
            end
          end
        end
      endcase
    end
  end

  always_comb begin
    ev_next = '0;
    ev_next[EV_LOCK]      = status_next[ST_LOCK_BIT] && !status_reg[ST_LOCK_BIT];
    ev_next[EV_SRM_LOCK]  = status_next[ST_SRM_BIT] && !status_reg[ST_SRM_BIT];
    ev_next[EV_MCLK_LOST] = !status_next[ST_MCLK_BIT] && status_reg[ST_MCLK_BIT];
    ev_next[EV_TRIM_DONE] = (trim_state_reg == TRIM_RUN) && cal_en_reg
                            && step_cnt_reg == 16'h0001 && bit_reg == 3'h0;
  end

  // Sticky events; a new event wins over a write-one clear.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      irq_stat_reg <= '0;
      irq_o        <= 1'b0;
    end else if (ce_i) begin
      if (wr_en && idx == IDX_IRQ_STAT) begin
        irq_stat_reg <= (irq_stat_reg & ~pwdata_i[NUM_EV-1:0]) | ev_next;
      end else begin
        irq_stat_reg <= irq_stat_reg | ev_next;
      end
      irq_o <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  bypass_src_a: assert property (ce_i && mode_reg == MODE_BYPASS |=> !loop_en_o && clk_src_o == SRC_MCLK)
    else $error("Bypass mode did not select the master clock.");
  normal_src_a: assert property (ce_i && mode_reg == MODE_NORMAL |=> loop_en_o && clk_src_o == SRC_LOOP_MCLK)
    else $error("Normal mode did not enable the loop.");
  track_src_a: assert property (ce_i && mode_reg == MODE_TRACK |=> loop_en_o && clk_src_o == SRC_LOOP_WCLK)
    else $error("Tracking mode did not follow the word clock.");
  mode_write_a: assert property (ce_i && wr_en && idx == IDX_LOOP_CTRL |=> mode_reg == $past(pwdata_i[7:6]) && sqr_reg == $past(pwdata_i[4]))
    else $error("Loop control write not stored.");
  squarer_out_a: assert property (ce_i ##1 ce_i |-> sqr_en_o == $past(sqr_reg))
    else $error("Squarer enable does not follow its bit.");
  commit_only_a: assert property (ce_i && !(wr_en && idx == IDX_INTEGER) |=> $stable(fb_frac_o) && $stable(fb_int_o))
    else $error("Feedback divider changed without an integer write.");
  frac_join_a: assert property (ce_i && wr_en && idx == IDX_INTEGER |=> fb_frac_o == {$past(frac_hi_reg), $past(frac_lo_reg)})
    else $error("Fraction not committed from both parts.");
  status_unused_a: assert property (status_reg[6:5] == 2'h0 && status_reg[2:1] == 2'h0)
    else $error("Unused status bits set.");
  track_lock_a: assert property (status_reg[ST_SRM_BIT] |-> $past(mode_reg) == MODE_TRACK)
    else $error("Tracking lock shown outside tracking mode.");
  osc_run_a: assert property (ce_i && !status_reg[ST_MCLK_BIT] && !standby_i |=> osc_run_o)
    else $error("Reference oscillator not run without master clock.");
  trim_start_a: assert property (ce_i && start_trim |=> trim_busy_o && osc_trim_o == 5'h10)
    else $error("Trimming did not start.");
  trim_gate_a: assert property (trim_busy_o |-> cal_en_reg || $past(cal_en_reg))
    else $error("Trimming runs with engine disabled.");
  bias_out_a: assert property (ce_i ##1 ce_i |-> bias_en_o == $past(bias_reg))
    else $error("Bias enable does not follow its bit.");
  ready_pulse_a: assert property (ce_i && pready_o |=> !pready_o)
    else $error("Bus ready stood longer than one cycle.");
  irq_set_a: assert property (ce_i && ev_next[EV_TRIM_DONE] |=> irq_stat_reg[EV_TRIM_DONE])
    else $error("Trim done event not latched.");
  irq_level_a: assert property (ce_i && |(irq_stat_reg & irq_mask_reg) |=> irq_o)
    else $error("Interrupt not raised for an unmasked event.");
  trim_done_a: assert property (ce_i && ev_next[EV_TRIM_DONE] |=> !trim_busy_o)
    else $error("Trimming still busy after its last step.");

endmodule
`default_nettype wire

// >>> shared/apll_pkg.sv
/*
  Shared constants of the audio clock generator control block.
  Assumes a 20 MHz register clock and word-indexed register addresses.
*/
`default_nettype none
package apll_pkg;
  localparam int          CLK_MHZ         = 20;
  localparam int          CLK_NS          = 1000 / CLK_MHZ;
  // Register indices; byte address is four times the index.
  localparam logic [7:0]  IDX_LOOP_CTRL   = 8'h91;
  localparam logic [7:0]  IDX_FRAC_HIGH   = 8'h92;
  localparam logic [7:0]  IDX_FRAC_LOW    = 8'h93;
  localparam logic [7:0]  IDX_INTEGER     = 8'h94;
  localparam logic [7:0]  IDX_STATUS      = 8'h95;
  localparam logic [7:0]  IDX_OSC_TRIM    = 8'h98;
  localparam logic [7:0]  IDX_REF_EN      = 8'hdc;
  localparam logic [7:0]  IDX_IRQ_STAT    = 8'he0;
  localparam logic [7:0]  IDX_IRQ_MASK    = 8'he1;
  // Field positions.
  localparam int          MODE_LSB        = 6;
  localparam int          SQR_BIT         = 4;
  localparam int          CAL_EN_BIT      = 7;
  localparam int          CAL_START_BIT   = 6;
  localparam int          BIAS_BIT        = 3;
  localparam int          ST_MCLK_BIT     = 0;
  localparam int          ST_LOCK_BIT     = 3;
  localparam int          ST_ACT_BIT      = 4;
  localparam int          ST_SRM_BIT      = 7;
  // Mode codes.
  localparam logic [1:0]  MODE_BYPASS     = 2'h0;
  localparam logic [1:0]  MODE_NORMAL     = 2'h1;
  localparam logic [1:0]  MODE_TRACK      = 2'h2;
  // Clock source codes driven to the clock mux.
  localparam logic [1:0]  SRC_MCLK        = 2'h0;
  localparam logic [1:0]  SRC_LOOP_MCLK   = 2'h1;
  localparam logic [1:0]  SRC_LOOP_WCLK   = 2'h2;
  // Reset values.
  localparam logic [2:0]  RST_INDIV       = 3'h4;
  localparam logic [6:0]  RST_INTEGER     = 7'h20;
  localparam logic        RST_BIAS        = 1'h1;
  // Interrupt event bits.
  localparam int          EV_LOCK         = 0;
  localparam int          EV_SRM_LOCK     = 1;
  localparam int          EV_MCLK_LOST    = 2;
  localparam int          EV_TRIM_DONE    = 3;
  localparam int          NUM_EV          = 4;
  // Timing.
  localparam int          ACT_WINDOW_NS   = 1000;
  localparam int          ACT_WINDOW_CYC  = ACT_WINDOW_NS / CLK_NS;
  localparam int          TRIM_STEP_NS    = 1000;
  localparam int          TRIM_STEP_CYC   = (TRIM_STEP_NS + CLK_NS - 1) / CLK_NS;
endpackage
`default_nettype wire

// >>> test/apll_clk_src.sv
/*
  Model of the external master clock source and the audio word clock.
  Assumes the bench gates each clock with a level enable; a stopped clock stands still.
*/
`timescale 1ns/100ps
`default_nettype none
module apll_clk_src #(
  parameter int MCLK_HALF_NS = 12,
  parameter int WCLK_HALF_NS = 80
) (
  input  wire logic mclk_on_i,
  input  wire logic wclk_on_i,
  output logic      mclk_o,
  output logic      wclk_o
);
  // Master clock near 41.7 MHz, inside the top reference band.
  initial mclk_o = 1'b0;
  initial wclk_o = 1'b0;
  always #(MCLK_HALF_NS) if (mclk_on_i) mclk_o = ~mclk_o;
  always #(WCLK_HALF_NS) if (wclk_on_i) wclk_o = ~wclk_o;
endmodule
`default_nettype wire

// >>> test/apll_ctrl_tb.sv
/*
  Self-checking bench of the clock generator control block.
  Assumes shortened activity and trim step counts and an APB master here.
*/
`timescale 1ns/100ps
`default_nettype none
module apll_ctrl_tb;
  import apll_pkg::*;
  // Must exceed the six-cycle gap between sampled edges of the model's master clock.
  localparam int ACT  = 8;
  localparam int STEP = 4;
  logic        clk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [9:0]  paddr = 10'h0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, mclk, wclk, loop_en, sqr_en, osc_run, busy, bias_en, irq;
  logic        loop_lock = 1'b0, track_lock = 1'b0, osc_fast = 1'b0, standby = 1'b0;
  logic        mclk_on = 1'b0, wclk_on = 1'b0;
  logic        ce = 1'b1;
  logic [1:0]  clk_src;
  logic [2:0]  ref_band;
  logic [6:0]  fb_int;
  logic [12:0] fb_frac;
  logic [4:0]  trim;
  int          miscompares = 0;
  int          comparisons = 0;

  always #25 clk_i = ~clk_i;

  apll_clk_src i_apll_clk_src (.mclk_on_i(mclk_on), .wclk_on_i(wclk_on), .mclk_o(mclk),
    .wclk_o(wclk));
  apll_ctrl #(.ACT_CYC(ACT), .STEP_CYC(STEP)) i_apll_ctrl (.clk_i(clk_i), .srst_i(srst_i),
    .ce_i(ce), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .mclk_i(mclk), .wclk_i(wclk), .loop_lock_i(loop_lock), .track_lock_i(track_lock),
    .osc_fast_i(osc_fast), .standby_i(standby), .loop_en_o(loop_en), .clk_src_o(clk_src),
    .sqr_en_o(sqr_en), .ref_band_o(ref_band), .fb_int_o(fb_int), .fb_frac_o(fb_frac),
    .osc_run_o(osc_run), .osc_trim_o(trim), .trim_busy_o(busy), .bias_en_o(bias_en),
    .irq_o(irq));

  task automatic tally_and_finish();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic hang();
    miscompares++;
    $display("timeout at %0t", $time);
    tally_and_finish();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge clk_i);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= wd;
    @(posedge clk_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) hang();
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, idx, d, r, e);
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, idx, 32'h0, r, e);
    chk(r, exp);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic poll_stat(input logic [7:0] exp);
    logic [31:0] r;
    logic        e;
    int          n;
    n = 0;
    do begin
      apb(1'b0, IDX_STATUS, 32'h0, r, e);
      n++;
    end while (r[7:0] !== exp && n < 40);
    if (n == 40) hang();
    chk(r, {24'h0, exp});
  endtask

  task automatic poll_run(input logic exp);
    int n;
    n = 0;
    while (osc_run !== exp && n < 60) begin
      @(posedge clk_i);
      n++;
    end
    if (n == 60) hang();
    chk({31'h0, osc_run}, {31'h0, exp});
  endtask

  task automatic t_reset();
    logic [31:0] r;
    logic        e;
    rdc(IDX_LOOP_CTRL, 32'h04);
    rdc(IDX_FRAC_HIGH, 32'h00);
    rdc(IDX_FRAC_LOW, 32'h00);
    rdc(IDX_INTEGER, 32'h20);
    rdc(IDX_OSC_TRIM, 32'h00);
    rdc(IDX_REF_EN, 32'h08);
    wr(IDX_STATUS, 32'hff);
    rdc(IDX_STATUS, 32'h00);
    chk({8'h0, bias_en, ref_band, fb_int, fb_frac}, {8'h0, 1'b1, 3'h4, 7'h20, 13'h0});
    chk({28'h0, loop_en, clk_src, sqr_en}, 32'h0);
    chk({31'h0, osc_run}, 32'h1);
    apb(1'b0, 8'h96, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
    $display("reset test done");
  endtask

  task automatic t_modes();
    logic [31:0] d;
    logic [1:0]  src;
    for (int m = 0; m < 4; m++) begin
      d = {24'h0, 2'(m), 1'b0, 1'(m), 1'b0, 3'(m + 3)};
      src = (m == 3) ? 2'h0 : 2'(m);
      wr(IDX_LOOP_CTRL, d);
      tick(2);
      chk({25'h0, loop_en, clk_src, sqr_en, ref_band}, {25'h0, src != 2'h0, src, d[4], d[2:0]});
      rdc(IDX_LOOP_CTRL, d);
    end
    $display("mode test done");
  endtask

  task automatic t_fraction();
    wr(IDX_FRAC_HIGH, 32'h15);
    wr(IDX_FRAC_LOW, 32'hff);
    tick(2);
    chk({19'h0, fb_frac}, 32'h0);
    rdc(IDX_FRAC_HIGH, 32'h15);
    rdc(IDX_FRAC_LOW, 32'hff);
    wr(IDX_INTEGER, 32'h7f);
    tick(2);
    chk({12'h0, fb_int, fb_frac}, {12'h0, 7'h7f, 5'h15, 8'hff});
    rdc(IDX_INTEGER, 32'h7f);
    $display("fraction test done");
  endtask

  task automatic t_status();
    wr(IDX_LOOP_CTRL, 32'h44);
    loop_lock <= 1'b1;
    mclk_on   <= 1'b1;
    poll_stat(8'h19);
    poll_run(1'b0);
    wr(IDX_LOOP_CTRL, 32'h84);
    wclk_on    <= 1'b1;
    track_lock <= 1'b1;
    poll_stat(8'h99);
    wr(IDX_LOOP_CTRL, 32'h04);
    poll_stat(8'h01);
    mclk_on <= 1'b0;
    poll_run(1'b1);
    standby <= 1'b1;
    poll_run(1'b0);
    standby <= 1'b0;
    mclk_on <= 1'b1;
    $display("status test done");
  endtask

  task automatic t_trim_irq();
    int n;
    wr(IDX_IRQ_STAT, 32'hff);
    wr(IDX_IRQ_MASK, 32'h00);
    wr(IDX_OSC_TRIM, 32'h40);
    tick(2);
    chk({31'h0, busy}, 32'h0);
    wr(IDX_OSC_TRIM, 32'hc0);
    tick(2);
    chk({31'h0, busy}, 32'h1);
    n = 0;
    while (busy !== 1'b0 && n < 300) begin
      @(posedge clk_i);
      n++;
    end
    if (n == 300) hang();
    tick(1);
    chk({27'h0, trim}, 32'h1f);
    rdc(IDX_OSC_TRIM, 32'h9f);
    wr(IDX_OSC_TRIM, 32'h80);
    tick(2);
    chk({31'h0, busy}, 32'h0);
    rdc(IDX_IRQ_STAT, 32'h08);
    chk({31'h0, irq}, 32'h0);
    wr(IDX_IRQ_MASK, 32'h08);
    tick(2);
    chk({31'h0, irq}, 32'h1);
    wr(IDX_IRQ_STAT, 32'h08);
    tick(2);
    chk({31'h0, irq}, 32'h0);
    rdc(IDX_IRQ_STAT, 32'h00);
    osc_fast <= 1'b1;
    wr(IDX_OSC_TRIM, 32'hc0);
    tick(2);
    n = 0;
    while (busy !== 1'b0 && n < 300) begin
      @(posedge clk_i);
      n++;
    end
    if (n == 300) hang();
    tick(1);
    chk({27'h0, trim}, 32'h00);
    rdc(IDX_OSC_TRIM, 32'h80);
    osc_fast <= 1'b0;
    $display("trim and interrupt test done");
  endtask

  task automatic t_bias();
    wr(IDX_REF_EN, 32'h00);
    tick(2);
    chk({31'h0, bias_en}, 32'h0);
    rdc(IDX_REF_EN, 32'h00);
    wr(IDX_REF_EN, 32'h08);
    tick(2);
    chk({31'h0, bias_en}, 32'h1);
    $display("bias test done");
  endtask

  task automatic t_freeze();
    @(posedge clk_i);
    ce      <= 1'b0;
    mclk_on <= 1'b0;
    repeat (30) @(posedge clk_i);
    chk({31'h0, osc_run}, 32'h0);
    ce <= 1'b1;
    poll_run(1'b1);
    mclk_on <= 1'b1;
    $display("freeze test done");
  endtask

  initial begin
    repeat (12) @(posedge clk_i);
    srst_i <= 1'b0;
    t_reset();
    t_modes();
    t_fraction();
    t_status();
    t_trim_irq();
    t_bias();
    t_freeze();
    tally_and_finish();
  end
endmodule
`default_nettype wire
